// >>> hw/mmc_staging.sv
/*
 * mmc_staging: multi-motor staging controller core. Switches auxiliary
 * motor relays, sleeps and wakes, rotates the start motor, honours
 * interlock inputs and runs the fill phase before regulation.
 * Assumes: settings and process values are synchronous to i_mclk and
 * stay stable between updates; the speed ramp and the regulator sit
 * outside and follow the ramp and override outputs.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - below sleep frequency for the sleep delay: stop motor, go asleep
// - a zero sleep delay disables sleeping altogether
// - asleep, wake when feedback strays from target past wake level
// - mode 0: relays on cyclically from fixed start, off in reverse
// - mode 1: as mode 0 but start relay advances on each auto change
// - mode 2: every motor on relays, rotation as in mode 1
// - auto change needs interval, low feedback and motor count match
// - auto change stops the motor, advances order, then carries on
// - interval counter runs only while an auxiliary motor runs
// - mode 2: frequency below change level forces change to next motor
// - with interlock on, an off input removes its motor from staging
// - run from stop stages in normal order skipping blocked relays
// - interlock drop while running: all off, restage without it
// - four auxiliaries, seven with option board, own thresholds each
// - stage next motor: speed over start freq past delay, deficit big
// - destage: speed under stop freq past delay, excess pressure big
// - after staging, ramp main frequency down over stage decel time
// - after destaging, ramp main frequency up over destage accel time
// - pressure difference threshold, default 2 %, gates stage decisions
// - fill phase drives the fill frequency until the phase finishes
// - fill phase ends when feedback exceeds the exit level
// - still below exit level after the fill timeout: malfunction
module mmc_staging
	import mmc_pkg::*;
#(
	parameter int NAUX        = MMC_BASE_AUX,
	parameter int TICK_CYCLES = MMC_TICK_CYC
) (
	// clock and reset
	input  wire logic                   i_mclk,
	input  wire logic                   i_reset_n,
	// run command and settings
	input  wire logic                   i_run,
	input  wire mmc_cfg_t               i_cfg,
	// process values
	input  wire mmc_proc_t              i_proc,
	// interlock inputs, high = motor usable
	input  wire logic [MMC_MAX_AUX-1:0] i_interlock_inputs,
	// relay outputs
	output logic [MMC_MAX_AUX-1:0]      o_aux_outputs,
	output logic [2:0]                  o_running_count,
	// drive control
	output logic                        o_drive_run,
	output logic                        o_asleep,
	output logic                        o_prereg_phase,
	output logic [15:0]                 o_freq_override,
	// ramp request
	output logic                        o_ramp_load,
	output logic                        o_ramp_accel,
	output logic [15:0]                 o_ramp_time,
	// fault
	output logic                        o_malfunction
);
	if (NAUX < 1 || NAUX > MMC_MAX_AUX) begin : g_chk
		$error("mmc_staging: NAUX must lie in 1..7");
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------

	// relays of the first cnt usable positions counted from start
	function automatic logic [MMC_MAX_AUX-1:0] relay_mask(
		input logic [2:0]             start,
		input logic [2:0]             cnt,
		input logic [MMC_MAX_AUX-1:0] en,
		input logic [2:0]             n
	);
		logic [MMC_MAX_AUX-1:0] m;
		logic [3:0]             idx;
		logic [2:0]             done;
		m = '0;
		done = 3'h0;
		for (int k = 0; k < MMC_MAX_AUX; k++) begin
			idx = 4'(start) + 4'(k);
			if (idx >= 4'(n)) begin
				idx = idx - 4'(n);
			end
			if (3'(k) < n && en[idx[2:0]] && done < cnt) begin
				m[idx[2:0]] = 1'b1;
				done = done + 3'h1;
			end
		end
		return m;
	endfunction

	// ---------------------------------------------------------------
	// derived values
	// ---------------------------------------------------------------
	localparam logic [2:0] NMAX = 3'(NAUX);

	mmc_core_t              q;
	mmc_core_t              next_q;
	logic                   tick;
	logic [MMC_NTMR-1:0]    t_count;
	logic [MMC_NTMR-1:0]    t_clear;
	logic [MMC_NTMR-1:0]    t_done;
	logic [MMC_NTMR-1:0][MMC_TW-1:0] t_limit;
	logic [2:0]             n;
	logic [MMC_MAX_AUX-1:0] en;
	logic [2:0]             avail;
	logic [2:0]             base;
	logic [2:0]             start_i;
	logic [2:0]             aux_idx;
	logic signed [16:0]     dev;
	logic signed [16:0]     thr;
	logic signed [16:0]     wake;
	logic                   deficit;
	logic                   excess;
	logic                   c_start;
	logic                   c_stop;
	logic                   c_sleep;
	logic                   c_pre;
	logic                   lost;
	logic                   ac_fire;
	logic                   mode2;

	// motor count, usable mask and offsets
	always_comb begin
		n = (i_cfg.aux_count > NMAX) ? NMAX : i_cfg.aux_count;
		en = '0;
		avail = 3'h0;
		for (int k = 0; k < MMC_MAX_AUX; k++) begin
			if (3'(k) < n) begin
				en[k] = !i_cfg.interlock_enable
					|| i_interlock_inputs[k];
			end
			avail = avail + {2'h0, en[k]};
		end
		mode2 = (i_cfg.rotation_mode_select == MMC_ROT_ALL);
		base = mode2 ? 3'h1 : 3'h0;
		start_i = (q.start >= n) ? 3'h0 : q.start;
		aux_idx = q.staged - base;
	end

	// reference minus feedback and its thresholds
	always_comb begin
		dev = $signed({1'b0, i_proc.reference})
			- $signed({1'b0, i_proc.feedback});
		thr = $signed({1'b0, i_cfg.pressure_diff_threshold});
		wake = $signed({1'b0, i_cfg.wake_level});
		deficit = dev > thr;
		excess = -dev > thr;
	end

	// decision conditions
	always_comb begin
		c_start = (q.st == MMC_REGUL) && (q.staged < avail)
			&& (aux_idx < NMAX)
			&& (i_proc.output_freq
				> i_cfg.aux_start_frequencies[aux_idx])
			&& deficit;
		c_stop = (q.st == MMC_REGUL) && (q.staged > base)
			&& (i_proc.output_freq
				< i_cfg.aux_stop_frequencies[aux_idx - 3'h1])
			&& excess;
		c_sleep = (q.st == MMC_REGUL) && (q.staged <= base)
			&& (i_cfg.sleep_delay_time != 16'h0)
			&& (i_proc.output_freq < i_cfg.sleep_frequency);
		c_pre = (q.st == MMC_PREREG)
			&& (i_proc.feedback <= i_cfg.prereg_exit_level);
		lost = i_cfg.interlock_enable && (q.st == MMC_REGUL)
			&& |(q.prev_en & ~en & q.relays);
	end

	// auto change trigger
	always_comb begin
		ac_fire = 1'b0;
		if (q.st == MMC_REGUL && t_done[MMC_T_ROT]) begin
			if (i_cfg.rotation_mode_select == MMC_ROT_AUX) begin
				ac_fire = (q.staged == 3'h0)
					&& (i_proc.feedback
						< i_cfg.rotation_feedback_level);
			end else if (mode2) begin
				ac_fire = (q.staged == 3'h1)
					&& ((i_proc.feedback
						< i_cfg.rotation_feedback_level)
					|| (i_proc.output_freq
						< i_cfg.rotation_feedback_level));
			end
		end
	end

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------

	// timer enables, clears and limits
	always_comb begin
		t_count[MMC_T_SLEEP] = c_sleep;
		t_count[MMC_T_START] = c_start;
		t_count[MMC_T_STOP]  = c_stop;
		t_count[MMC_T_PRE]   = c_pre;
		t_count[MMC_T_ROT]   = (q.st == MMC_REGUL)
			&& (q.staged > base);
		t_clear = ~t_count;
		t_clear[MMC_T_ROT] = ac_fire || (q.st == MMC_IDLE);
		t_clear[MMC_T_START] = !c_start || t_done[MMC_T_START];
		t_clear[MMC_T_STOP] = !c_stop || t_done[MMC_T_STOP];
		t_limit[MMC_T_SLEEP] = MMC_TW'(i_cfg.sleep_delay_time);
		t_limit[MMC_T_START] = MMC_TW'(i_cfg.aux_start_delay);
		t_limit[MMC_T_STOP]  = MMC_TW'(i_cfg.aux_stop_delay);
		t_limit[MMC_T_PRE]   = MMC_TW'(i_cfg.prereg_timeout);
		t_limit[MMC_T_ROT]   = i_cfg.rotation_interval;
	end

	mmc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.o_tick    (tick)
	);

	for (genvar g = 0; g < MMC_NTMR; g++) begin : g_tmr
		mmc_timer u_tmr (
			.i_mclk    (i_mclk),
			.i_reset_n (i_reset_n),
			.i_tick    (tick),
			.i_count   (t_count[g]),
			.i_clear   (t_clear[g]),
			.i_limit   (t_limit[g]),
			.o_done    (t_done[g])
		);
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------

	// next state, stage count and relay pattern
	always_comb begin
		next_q = q;
		next_q.ramp_load = 1'b0;
		next_q.prev_en = en;
		case (q.st)
			MMC_IDLE: begin
				next_q.staged = 3'h0;
				next_q.start = i_cfg.start_aux;
				if (i_run && i_cfg.prereg_enable) begin
					next_q.st = MMC_PREREG;
				end else if (i_run) begin
					next_q.st = MMC_REGUL;
					next_q.staged = base;
				end
			end
			MMC_PREREG: begin
				if (!c_pre) begin
					next_q.st = MMC_REGUL;
					next_q.staged = base;
				end else if (t_done[MMC_T_PRE]) begin
					next_q.malfunction = 1'b1;
				end
			end
			MMC_REGUL: begin
				if (lost) begin
					next_q.st = MMC_RESTAGE;
					next_q.staged = 3'h0;
				end else if (ac_fire) begin
					next_q.st = MMC_RESTAGE;
					next_q.staged = 3'h0;
					next_q.start = (start_i + 3'h1 >= n)
						? 3'h0 : start_i + 3'h1;
				end else if (t_done[MMC_T_SLEEP]) begin
					next_q.st = MMC_SLEEP;
					next_q.staged = 3'h0;
				end else if (t_done[MMC_T_START]) begin
					next_q.staged = q.staged + 3'h1;
					next_q.ramp_load = 1'b1;
					next_q.ramp_accel = 1'b0;
					next_q.ramp_time = i_cfg.stage_decel_time;
				end else if (t_done[MMC_T_STOP]) begin
					next_q.staged = q.staged - 3'h1;
					next_q.ramp_load = 1'b1;
					next_q.ramp_accel = 1'b1;
					next_q.ramp_time = i_cfg.destage_accel_time;
				end
			end
			MMC_SLEEP: begin
				if (dev > wake || -dev > wake) begin
					next_q.st = MMC_REGUL;
					next_q.staged = base;
				end
			end
			MMC_RESTAGE: begin
				next_q.st = MMC_REGUL;
				next_q.staged = base;
			end
			default: begin
				next_q.st = MMC_IDLE;
			end
		endcase
		if (!i_run) begin
			next_q.st = MMC_IDLE;
			next_q.staged = 3'h0;
			next_q.malfunction = 1'b0;
		end
		if (next_q.st == MMC_REGUL) begin
			next_q.relays = relay_mask(next_q.start,
				next_q.staged, en, n);
		end else begin
			next_q.relays = '0;
		end
		next_q.drive_run = (next_q.st == MMC_PREREG)
			|| (next_q.st == MMC_REGUL);
		next_q.ovr_en = (next_q.st == MMC_PREREG);
		next_q.ovr_freq = i_cfg.prereg_frequency;
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_aux_outputs   = q.relays;
	assign o_running_count = q.staged;
	assign o_drive_run     = q.drive_run;
	assign o_asleep        = (q.st == MMC_SLEEP);
	assign o_prereg_phase  = q.ovr_en;
	assign o_freq_override = q.ovr_freq;
	assign o_ramp_load     = q.ramp_load;
	assign o_ramp_accel    = q.ramp_accel;
	assign o_ramp_time     = q.ramp_time;
	assign o_malfunction   = q.malfunction;
endmodule // mmc_staging
`default_nettype wire

// >>> hw/mmc_tick.sv
/*
 * mmc_tick: one-cycle pulse every TICK_CYCLES clocks, the common time
 * base of all delay timers.
 * Assumes: free-running control clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mmc_tick
	import mmc_pkg::*;
#(
	parameter int TICK_CYCLES = MMC_TICK_CYC
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_reset_n,
	// time base
	output logic      o_tick
);
	if (TICK_CYCLES < 1) begin : g_chk
		$error("mmc_tick: TICK_CYCLES must be at least one");
	end

	localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

	mmc_tick_t q;
	mmc_tick_t next_q;

	// wrap counter, pulse on wrap
	always_comb begin
		next_q = q;
		next_q.tick = (q.cnt == LAST);
		next_q.cnt = next_q.tick ? 32'h0 : q.cnt + 32'h1;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_tick = q.tick;
endmodule // mmc_tick
`default_nettype wire

// >>> hw/mmc_timer.sv
/*
 * mmc_timer: delay timer counted in ticks; done once the count
 * reaches the limit, held while paused, zeroed by clear.
 * Assumes: i_tick is a one-cycle pulse from mmc_tick.
 */
`timescale 1ns/1ps
`default_nettype none
module mmc_timer
	import mmc_pkg::*;
(
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_reset_n,
	// control
	input  wire logic              i_tick,
	input  wire logic              i_count,
	input  wire logic              i_clear,
	input  wire logic [MMC_TW-1:0] i_limit,
	// status
	output logic                   o_done
);
	mmc_tmr_t q;
	mmc_tmr_t next_q;

	// count on ticks while enabled, saturate at the limit
	always_comb begin
		next_q = q;
		if (i_clear) begin
			next_q.cnt = '0;
		end else if (i_count && i_tick && !q.done) begin
			next_q.cnt = q.cnt + 1'b1;
		end
		next_q.done = !i_clear && (next_q.cnt >= i_limit);
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_done = q.done;
endmodule // mmc_timer
`default_nettype wire

// >>> include/mmc_pkg.sv
/*
 * mmc_pkg: shared constants, modes, states and carrier structs for the
 * multi-motor staging controller.
 * Assumes: 40 MHz control clock; times in 0.1 s units, frequencies in
 * 0.01 Hz units, process values and levels in 0.1 % units.
 */
`default_nettype none
package mmc_pkg;

	// ---------------------------------------------------------------
	// sizing and timing
	// ---------------------------------------------------------------
	localparam int MMC_MAX_AUX  = 7;	// with option board
	localparam int MMC_BASE_AUX = 4;	// without option board
	localparam int MMC_CLK_NS   = 25;
	localparam int MMC_TICK_NS  = 100_000_000;	// 0.1 s time unit
	localparam int MMC_TICK_CYC = MMC_TICK_NS / MMC_CLK_NS;
	localparam int MMC_TW       = 20;	// timer count width

	// ---------------------------------------------------------------
	// documented setting defaults (software loads these)
	// ---------------------------------------------------------------
	localparam logic [15:0] MMC_SLEEP_DELAY_DEF = 16'h0258; // 60.0 s
	localparam logic [15:0] MMC_SLEEP_FREQ_DEF  = 16'h0000; // 0.00 Hz
	localparam logic [15:0] MMC_WAKE_LEVEL_DEF  = 16'h0014; // 2.0 %
	localparam logic [15:0] MMC_PDIFF_DEF       = 16'h0014; // 2 %
	localparam logic [15:0] MMC_PRE_FREQ_DEF    = 16'h0000; // 0.00 Hz
	localparam logic [15:0] MMC_PRE_EXIT_DEF    = 16'h0000; // 0.0 %
	localparam logic [15:0] MMC_PRE_TO_DEF      = 16'h1770; // 600 s

	// ---------------------------------------------------------------
	// timer slots
	// ---------------------------------------------------------------
	localparam int MMC_T_SLEEP = 0;
	localparam int MMC_T_START = 1;
	localparam int MMC_T_STOP  = 2;
	localparam int MMC_T_PRE   = 3;
	localparam int MMC_T_ROT   = 4;
	localparam int MMC_NTMR    = 5;

	// ---------------------------------------------------------------
	// modes and states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MMC_ROT_FIXED = 2'h0,	// fixed starting relay
		MMC_ROT_AUX   = 2'h1,	// rotate auxiliaries only
		MMC_ROT_ALL   = 2'h2	// all motors on relays
	} mmc_rot_t;

	typedef enum logic [2:0] {
		MMC_IDLE    = 3'h0,
		MMC_PREREG  = 3'h1,
		MMC_REGUL   = 3'h3,
		MMC_SLEEP   = 3'h2,
		MMC_RESTAGE = 3'h6
	} mmc_state_t;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [MMC_MAX_AUX-1:0][15:0] aux_start_frequencies;
		logic [MMC_MAX_AUX-1:0][15:0] aux_stop_frequencies;
		logic [15:0] sleep_frequency;
		logic [15:0] sleep_delay_time;
		logic [15:0] wake_level;
		logic [15:0] rotation_feedback_level;
		logic [MMC_TW-1:0] rotation_interval;
		logic [15:0] aux_start_delay;
		logic [15:0] aux_stop_delay;
		logic [15:0] destage_accel_time;
		logic [15:0] stage_decel_time;
		logic [15:0] pressure_diff_threshold;
		logic [15:0] prereg_frequency;
		logic [15:0] prereg_exit_level;
		logic [15:0] prereg_timeout;
		logic [2:0]  aux_count;
		logic [2:0]  start_aux;	// zero-based
		mmc_rot_t    rotation_mode_select;
		logic        interlock_enable;
		logic        prereg_enable;
	} mmc_cfg_t;

	typedef struct packed {
		logic [15:0] output_freq;
		logic [15:0] reference;
		logic [15:0] feedback;
	} mmc_proc_t;

	typedef struct packed {
		mmc_state_t             st;
		logic [2:0]             staged;
		logic [2:0]             start;
		logic [MMC_MAX_AUX-1:0] relays;
		logic [MMC_MAX_AUX-1:0] prev_en;
		logic                   drive_run;
		logic                   ovr_en;
		logic [15:0]            ovr_freq;
		logic                   ramp_load;
		logic                   ramp_accel;
		logic [15:0]            ramp_time;
		logic                   malfunction;
	} mmc_core_t;

	typedef struct packed {
		logic [MMC_TW-1:0] cnt;
		logic              done;
	} mmc_tmr_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} mmc_tick_t;

endpackage
`default_nettype wire

// >>> testbench/mmc_plant.sv
/*
 * mmc_plant: far side of the staging controller: motor contacts that
 * report motor health and the process sensor.
 * Assumes: bench sets motor health and process level between edges.
 */
`timescale 1ns/1ps
`default_nettype none
module mmc_plant
	import mmc_pkg::*;
(
	// clock
	input  wire logic                   i_mclk,
	// relay drives and bench commands
	input  wire logic [MMC_MAX_AUX-1:0] i_aux_outputs,
	input  wire logic [MMC_MAX_AUX-1:0] i_motor_ok,
	input  wire logic [15:0]            i_level,
	// contacts and sensor
	output logic [MMC_MAX_AUX-1:0]      o_interlock_inputs,
	output logic [15:0]                 o_feedback,
	output logic [MMC_MAX_AUX-1:0]      o_motor_on
);
	// contacts follow motor health, sensor samples the level
	always_ff @(posedge i_mclk) begin
		o_interlock_inputs <= i_motor_ok;
		o_feedback         <= i_level;
		o_motor_on         <= i_aux_outputs & i_motor_ok;
	end
endmodule // mmc_plant
`default_nettype wire

// >>> testbench/mmc_staging_sva.sv
/*
 * mmc_staging_sva: port-level checks of the staging controller.
 * Assumes: bound to every mmc_staging instance; settings stay steady.
 */
`timescale 1ns/1ps
`default_nettype none
module mmc_staging_sva
	import mmc_pkg::*;
#(
	parameter int NAUX        = MMC_BASE_AUX,
	parameter int TICK_CYCLES = MMC_TICK_CYC
) (
	// clock, reset, inputs
	input  wire logic                   i_mclk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_run,
	input  wire mmc_cfg_t               i_cfg,
	input  wire mmc_proc_t              i_proc,
	input  wire logic [MMC_MAX_AUX-1:0] i_interlock_inputs,
	// watched outputs
	input  wire logic [MMC_MAX_AUX-1:0] o_aux_outputs,
	input  wire logic                   o_drive_run,
	input  wire logic                   o_asleep,
	input  wire logic                   o_prereg_phase,
	input  wire logic [15:0]            o_freq_override,
	input  wire logic                   o_ramp_load,
	input  wire logic                   o_ramp_accel,
	input  wire logic [15:0]            o_ramp_time,
	input  wire logic                   o_malfunction
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// ---------------------------------------------------------------
	// sequences
	// ---------------------------------------------------------------
	sequence s_fill_done;
		o_prereg_phase && i_run && i_proc.feedback > i_cfg.prereg_exit_level;
	endsequence
	sequence s_far_off;
		(i_proc.feedback > i_proc.reference + i_cfg.wake_level) ||
		(i_proc.reference > i_proc.feedback + i_cfg.wake_level);
	endsequence
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	stage_ramp_a: assert property (o_ramp_load && !o_ramp_accel |->
		o_ramp_time == $past(i_cfg.stage_decel_time)) else $error("bad ramp");
	destage_ramp_a: assert property (o_ramp_load && o_ramp_accel |->
		o_ramp_time == $past(i_cfg.destage_accel_time)) else $error("bad ramp");
	ramp_pulse_a: assert property (o_ramp_load |=> !o_ramp_load)
		else $error("ramp load too long");
	sleep_gate_a: assert property ($rose(o_asleep) |->
		$past(i_cfg.sleep_delay_time) != 16'h0) else $error("slept at zero");
	sleep_off_a: assert property (o_asleep |-> !o_drive_run &&
		o_aux_outputs == '0) else $error("motor on while asleep");
	wake_up_a: assert property (o_asleep && i_run ##0 s_far_off |=>
		!o_asleep) else $error("no wake");
	fill_freq_a: assert property (o_prereg_phase |->
		o_freq_override == $past(i_cfg.prereg_frequency)) else $error("fill");
	fill_exit_a: assert property (s_fill_done |=> !o_prereg_phase)
		else $error("fill phase kept");
	fault_fill_a: assert property ($rose(o_malfunction) |->
		$past(o_prereg_phase)) else $error("fault outside fill");
	relay_range_a: assert property ((o_aux_outputs >> NAUX) == '0)
		else $error("relay beyond count");
	interlock_drop_a: assert property (i_cfg.interlock_enable &&
		|(o_aux_outputs & ~i_interlock_inputs) |=> o_aux_outputs == '0)
		else $error("relays kept on interlock loss");
	skip_blocked_a: assert property ($past(i_cfg.interlock_enable) |->
		(o_aux_outputs & ~$past(o_aux_outputs) & ~$past(i_interlock_inputs))
		== '0) else $error("blocked relay on");
endmodule // mmc_staging_sva
bind mmc_staging mmc_staging_sva #(.NAUX(NAUX), .TICK_CYCLES(TICK_CYCLES))
	i_mmc_staging_sva (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_run(i_run), .i_cfg(i_cfg), .i_proc(i_proc),
	.i_interlock_inputs(i_interlock_inputs), .o_aux_outputs(o_aux_outputs),
	.o_drive_run(o_drive_run), .o_asleep(o_asleep),
	.o_prereg_phase(o_prereg_phase), .o_freq_override(o_freq_override),
	.o_ramp_load(o_ramp_load), .o_ramp_accel(o_ramp_accel),
	.o_ramp_time(o_ramp_time), .o_malfunction(o_malfunction));
`default_nettype wire

// >>> testbench/tb_top.sv
/*
 * tb_top: self-checking bench of the staging controller.
 * Assumes: tick shortened to 4 clocks, four motors, plant model beside.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mmc_pkg::*;
;
	logic        i_mclk, i_reset_n, i_run;
	mmc_cfg_t    i_cfg;
	mmc_proc_t   proc;
	logic [15:0] fq, rf, fb_set, fbk, ovr, rtm;
	logic [6:0]  ilk_mask, ilk, rel;
	logic [2:0]  cnt;
	logic        drv, slp, pre, rld, racc, mal;
	logic [6:0]  up [4] = '{7'h04, 7'h0c, 7'h0d, 7'h0f};
	int          mismatches, checks_done;
	assign proc = '{output_freq: fq, reference: rf, feedback: fbk};
	// ---------------------------------------------------------------
	// design and plant
	// ---------------------------------------------------------------
	mmc_staging #(.NAUX(4), .TICK_CYCLES(4)) i_mmc_staging (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_run(i_run),
		.i_cfg(i_cfg), .i_proc(proc), .i_interlock_inputs(ilk),
		.o_aux_outputs(rel), .o_running_count(cnt), .o_drive_run(drv),
		.o_asleep(slp), .o_prereg_phase(pre), .o_freq_override(ovr),
		.o_ramp_load(rld), .o_ramp_accel(racc), .o_ramp_time(rtm),
		.o_malfunction(mal));
	mmc_plant i_mmc_plant (.i_mclk(i_mclk), .i_aux_outputs(rel),
		.i_motor_ok(ilk_mask), .i_level(fb_set),
		.o_interlock_inputs(ilk), .o_feedback(fbk), .o_motor_on());
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// poll the relays each cycle under a bound
	task automatic wait_rel(input logic [6:0] e);
		int k;
		k = 0;
		while (rel !== e && k < 60) begin
			cyc(1);
			k++;
		end
		chk("relays", {9'h0, e}, {9'h0, rel});
		if (rel !== e)
			end_sim();
	endtask
	task automatic stop_run;
		i_run = 0;
		cyc(2);
	endtask
	// clock
	initial begin
		i_mclk = 0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	// main sequence
	initial begin
		mismatches = 0;
		checks_done = 0;
		{i_reset_n, i_run, fq} = '0;
		rf = 16'h01f4;
		fb_set = 16'h01f4;
		ilk_mask = 7'h7f;
		i_cfg = '0;
		i_cfg.aux_count = 3'h4;
		for (int k = 0; k < 7; k++) begin
			i_cfg.aux_start_frequencies[k] = 16'h03e8;
			i_cfg.aux_stop_frequencies[k] = 16'h01f4;
		end
		i_cfg.pressure_diff_threshold = MMC_PDIFF_DEF;
		i_cfg.wake_level = MMC_WAKE_LEVEL_DEF;
		i_cfg.stage_decel_time = 16'h0011;
		i_cfg.destage_accel_time = 16'h0022;
		i_cfg.aux_start_delay = 16'h0002;
		i_cfg.aux_stop_delay = 16'h0002;
		cyc(6);
		chk("reset", 16'h0, {4'h0, rel, drv, slp, pre, rld, mal});
		i_reset_n = 1;
		// fixed order from relay 2, small deficit first
		i_cfg.start_aux = 3'h2;
		fq = 16'h07d0;
		fb_set = 16'h01ea;
		i_run = 1;
		cyc(40);
		chk("no stage", 16'h0, {9'h0, rel});
		fb_set = 16'h0190;
		for (int i = 0; i < 4; i++)
			wait_rel(up[i]);
		chk("count", 16'h4, {13'h0, cnt});
		chk("decel", 16'h0011, rtm);
		chk("dir", 16'h0, {15'h0, racc});
		fq = 16'h0064;
		fb_set = 16'h0258;
		for (int i = 2; i >= 0; i--)
			wait_rel(up[i]);
		wait_rel(7'h00);
		chk("accel", 16'h0022, rtm);
		chk("dir", 16'h1, {15'h0, racc});
		$display("test staging finished");
		// interlock: relay 1 blocked, then relay 3 lost in run
		stop_run();
		i_cfg.interlock_enable = 1;
		i_cfg.start_aux = 3'h0;
		ilk_mask = 7'h7d;
		fq = 16'h07d0;
		fb_set = 16'h0190;
		i_run = 1;
		wait_rel(7'h01);
		wait_rel(7'h05);
		wait_rel(7'h0d);
		ilk_mask = 7'h75;
		wait_rel(7'h00);
		wait_rel(7'h01);
		wait_rel(7'h05);
		$display("test interlock finished");
		// sleep, wake, and a zero delay
		stop_run();
		i_cfg.interlock_enable = 0;
		ilk_mask = 7'h7f;
		fq = 16'h0064;
		fb_set = rf;
		i_cfg.sleep_frequency = 16'h01f4;
		i_cfg.sleep_delay_time = 16'h0002;
		i_run = 1;
		cyc(20);
		chk("asleep", 16'h1, {15'h0, slp});
		chk("drive", 16'h0, {15'h0, drv});
		fb_set = 16'h01d6;
		i_cfg.sleep_delay_time = 16'h0000;
		cyc(4);
		chk("woken", 16'h3, {14'h0, drv, ~slp});
		cyc(30);
		chk("no sleep", 16'h0, {15'h0, slp});
		$display("test sleep finished");
		// fill phase with timeout, then exit
		stop_run();
		i_cfg.sleep_frequency = 16'h0000;
		i_cfg.prereg_enable = 1;
		i_cfg.prereg_frequency = 16'h0123;
		i_cfg.prereg_exit_level = 16'h0064;
		i_cfg.prereg_timeout = 16'h0003;
		fb_set = 16'h0032;
		i_run = 1;
		cyc(3);
		chk("fill", 16'h1, {15'h0, pre});
		chk("fill freq", 16'h0123, ovr);
		cyc(20);
		chk("fault", 16'h1, {15'h0, mal});
		fb_set = 16'h0096;
		cyc(3);
		chk("fill end", 16'h0, {15'h0, pre});
		stop_run();
		chk("fault off", 16'h0, {15'h0, mal});
		$display("test fill finished");
		// rotation of the start relay
		i_cfg.prereg_enable = 0;
		i_cfg.rotation_mode_select = MMC_ROT_AUX;
		i_cfg.rotation_interval = 20'h00002;
		i_cfg.rotation_feedback_level = 16'h012c;
		i_cfg.aux_start_frequencies[1] = 16'hffff;
		fq = 16'h07d0;
		fb_set = 16'h0190;
		i_run = 1;
		wait_rel(7'h01);
		cyc(20);
		rf = 16'h00c8;
		fb_set = 16'h00fa;
		fq = 16'h0064;
		wait_rel(7'h00);
		cyc(4);
		rf = 16'h01f4;
		fq = 16'h07d0;
		wait_rel(7'h02);
		$display("test rotation finished");
		// mode 2: base motor on relays, low speed forces a change
		stop_run();
		i_cfg.rotation_mode_select = MMC_ROT_ALL;
		i_cfg.rotation_interval = 20'h00000;
		fb_set = 16'h01f4;
		i_run = 1;
		cyc(3);
		chk("base relay", 16'h0001, {9'h0, rel});
		fq = 16'h0064;
		wait_rel(7'h02);
		fq = 16'h07d0;
		cyc(4);
		chk("change held", 16'h0002, {9'h0, rel});
		$display("test mode two finished");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
